// ---- rtl/lsp_pkg.sv ----
// Package with register map, field layout, reset values and timing tables of the load switch.
package lsp_pkg;

  // Register offsets.
  localparam logic [7:0] ADDR_SWITCH_CONTROL = 8'h01;
  localparam logic [7:0] ADDR_LIVE_STATUS    = 8'h02;
  localparam logic [7:0] ADDR_FAULT_FLAGS    = 8'h03;
  localparam logic [7:0] ADDR_TRIP_LEVEL     = 8'h05;
  localparam logic [7:0] ADDR_PROBE_CURRENT  = 8'h06;
  localparam logic [7:0] ADDR_PROBE_TIMING   = 8'h07;
  localparam logic [7:0] ADDR_MEASURED_LEVEL = 8'h08;
  localparam logic [7:0] ADDR_TARGET_LEVEL   = 8'h09;
  localparam logic [7:0] ADDR_EXTRA_TRIP     = 8'h0E;
  localparam logic [7:0] ADDR_RAMP_CONFIG    = 8'h0F;

  // Field positions.
  localparam int BIT_SWITCH_ON   = 7;
  localparam int BIT_PROBE_MODE  = 6;
  localparam int BIT_REVERSE_STS = 0;
  localparam int BIT_PROBE_DONE  = 1;
  localparam int BIT_BELOW_TGT   = 2;
  localparam int BIT_INPUT_OK    = 3;
  localparam int BIT_INPUT_TRIP  = 0;
  localparam int BIT_THERMAL     = 1;
  localparam int BIT_OVERCURRENT = 2;
  localparam int POS_FINE_TRIM   = 4;

  // Values after reset.
  localparam logic [7:0] RST_SWITCH_CONTROL = 8'h00;
  localparam logic [1:0] RST_TRIP_LEVEL_SEL = 2'h0;
  localparam logic [2:0] RST_FINE_TRIM      = 3'h3;
  localparam logic [3:0] RST_PROBE_CURRENT  = 4'h0;
  localparam logic [3:0] RST_PULSE_WIDTH    = 4'h0;
  localparam logic [3:0] RST_REPEAT_PERIOD  = 4'h0;
  localparam logic [7:0] RST_TARGET_LEVEL   = 8'h00;
  localparam logic [1:0] RST_EXTRA_TRIP_SEL = 2'h0;
  localparam logic [2:0] RST_RAMP_TIME_SEL  = 3'h4;

  // Special codes.
  localparam logic [3:0] PULSE_ALWAYS_ON = 4'hF;
  localparam logic [3:0] PERIOD_SINGLE   = 4'h0;

  // Time base: one microsecond in clock cycles at 250 MHz.
  localparam int CLOCK_PERIOD_PS = 4000;
  localparam int MICROSECOND_PS  = 1000000;
  localparam int US_CYCLES       = MICROSECOND_PS / CLOCK_PERIOD_PS;

  // Turn-on ramp times in microseconds, by ramp code.
  function automatic logic [31:0] ramp_us(input logic [2:0] code);
    unique case (code)
      3'h0: ramp_us = 32'd420;
      3'h1: ramp_us = 32'd440;
      3'h2: ramp_us = 32'd500;
      3'h3: ramp_us = 32'd650;
      3'h4: ramp_us = 32'd900;
      3'h5: ramp_us = 32'd1500;
      3'h6: ramp_us = 32'd2800;
      3'h7: ramp_us = 32'd5600;
    endcase
  endfunction

  // Probe pulse widths in microseconds; code F never expires.
  function automatic logic [31:0] pulse_us(input logic [3:0] code);
    unique case (code)
      4'h0: pulse_us = 32'd200;
      4'h1: pulse_us = 32'd400;
      4'h2: pulse_us = 32'd1000;
      4'h3: pulse_us = 32'd2000;
      4'h4: pulse_us = 32'd4000;
      4'h5: pulse_us = 32'd10000;
      4'h6: pulse_us = 32'd20000;
      4'h7: pulse_us = 32'd40000;
      4'h8: pulse_us = 32'd100000;
      4'h9: pulse_us = 32'd20000;
      4'hA: pulse_us = 32'd400000;
      4'hB: pulse_us = 32'd100000;
      4'hC: pulse_us = 32'd200000;
      4'hD: pulse_us = 32'd400000;
      4'hE: pulse_us = 32'd1000000;
      4'hF: pulse_us = 32'hFFFFFFFF;
    endcase
  endfunction

  // Repeat periods in microseconds; code 0 means a single pulse.
  function automatic logic [31:0] period_us(input logic [3:0] code);
    unique case (code)
      4'h0: period_us = 32'd0;
      4'h1: period_us = 32'd10000;
      4'h2: period_us = 32'd20000;
      4'h3: period_us = 32'd50000;
      4'h4: period_us = 32'd100000;
      4'h5: period_us = 32'd200000;
      4'h6: period_us = 32'd500000;
      4'h7: period_us = 32'd1000000;
      4'h8: period_us = 32'd2000000;
      4'h9: period_us = 32'd3000000;
      4'hA: period_us = 32'd6000000;
      4'hB: period_us = 32'd12000000;
      4'hC: period_us = 32'd30000000;
      4'hD: period_us = 32'd60000000;
      4'hE: period_us = 32'd120000000;
      4'hF: period_us = 32'd300000000;
    endcase
  endfunction

  // Analog comparator levels and pin states arriving from outside the clock domain.
  typedef struct packed {
    logic en_n;           // Active-low enable pin.
    logic above_lockout;  // Input rail above the low-input lockout level.
    logic above_trip;     // Input rail above the selected high-input trip level.
    logic temp_hot;       // Die above 140 C.
    logic temp_cool;      // Die below 115 C.
    logic overcurrent;    // Switch current above the short-circuit level.
    logic reverse_supply; // Reverse supply present on the output rail.
    logic ext_pin_low;    // External trip pin below 0.1 V.
  } lsp_pins_t;

  // Trip level selection handed to the analog comparator.
  typedef struct packed {
    logic       use_external;
    logic [1:0] trip_level_sel;
    logic [1:0] extra_trip_level_sel;
    logic [2:0] trip_fine_trim;
  } lsp_trip_t;

  typedef enum logic [1:0] {DET_IDLE, DET_ARMED, DET_PULSE, DET_WAIT} lsp_det_t;

endpackage

// ---- rtl/lsp_core.sv ----
// Control, protection, impedance probe and register file of the load switch.
//
// Notes on behaviour
// - With reverse supply, a thermal trip only flags and interrupts, switch stays.
// - Three-bit ramp field picks one of eight turn-on times, default 0.9 ms.
// - Enable low and input below lockout: switch held off.
// - Input above lockout, enable low, no fault: switch on, ignoring switch-on bit.
// - Enable pin high: switch off and block in low-power mode.
// - Input above trip level with enable low: switch off, input-trip flag set, interrupt raised.
// - Input back below trip level with no other fault: switch on again.
// - At power-up trip level comes from external pin, else internal default.
// - External trip pin below 0.1 V selects the internal default level.
// - Bits 1:0 of trip config pick 6.8, 11.5, 17 or 23 V.
// - Extra trip field codes 10 and 11 give 10 V and 14 V.
// - Bits 6:4 trim trip level in 200 mV steps, code 011 is zero.
// - Die above 140 C trips switch and flags; release below 115 C.
// - Overcurrent once fully on trips switch and flags; release when it clears.
// - Probing only with enable low and input below lockout; abort when above.
// - Result valid when pulse timer expires; probe-done set, interrupt raised.
// - Measured level stored in its register and compared with the target.
// - Measured level below target sets below-target status and interrupts.
// - Bits 3:0 of probe current register select the probe current.
// - Bits 7:4 of timing register pick pulse width; code 1111 always on.
// - Bits 3:0 of timing register pick repeat period; code 0000 single pulse.
// - Rising flag or status bit, except reverse supply, latches one interrupt event.
// - Fault flags clear only on host read or input below lockout.
`timescale 1ns/1ps
module lsp_core #(
  parameter int US_CYCLES = lsp_pkg::US_CYCLES
) (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire lsp_pkg::lsp_pins_t pin_in,
  input  wire logic [7:0]        adc_level,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic [7:0]             reg_rdata,
  output logic                   switch_on,
  output logic                   switch_full,
  output logic [2:0]             ramp_time_sel,
  output lsp_pkg::lsp_trip_t     trip_cfg,
  output logic [3:0]             probe_current_sel,
  output logic                   probe_active,
  output logic                   low_power,
  output logic                   irq
);

  // The 16-bit prescaler cannot serve a longer microsecond, and one cycle cannot tick.
  if (US_CYCLES < 2 || US_CYCLES > 65535) begin : g_bad_us_cycles
    $error("US_CYCLES out of range");
  end

  // Pin synchroniser; the first stage feeds the second only. It runs through reset so
  // that the trip source strap and the edge detectors see settled pins at release.
  lsp_pkg::lsp_pins_t pin_meta_ff;
  lsp_pkg::lsp_pins_t pin_ff;

  always_ff @(posedge clock) begin
    pin_meta_ff <= pin_in;
    pin_ff      <= pin_meta_ff;
  end

  // Microsecond tick shared by all timers.
  logic [15:0] tick_cnt_ff;
  logic        us_tick_ff;

  always_ff @(posedge clock) begin
    if (reset) begin
      tick_cnt_ff <= 16'h0000;
      us_tick_ff  <= 1'b0;
    end else if (tick_cnt_ff == 16'(US_CYCLES - 1)) begin
      tick_cnt_ff <= 16'h0000;
      us_tick_ff  <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 16'h0001;
      us_tick_ff  <= 1'b0;
    end
  end

  // Register file.
  logic       switch_on_bit_ff;
  logic       probe_mode_on_ff;
  logic [1:0] trip_level_sel_ff;
  logic [2:0] trip_fine_trim_ff;
  logic [1:0] extra_trip_level_sel_ff;
  logic [3:0] probe_current_sel_ff;
  logic [3:0] probe_pulse_width_sel_ff;
  logic [3:0] repeat_period_sel_ff;
  logic [7:0] compare_target_ff;
  logic [2:0] ramp_time_sel_ff;
  logic       wr_ctrl;
  logic       wr_trip;
  logic       wr_extra;
  logic       wr_target;

  assign wr_ctrl   = reg_write && reg_addr == lsp_pkg::ADDR_SWITCH_CONTROL;
  assign wr_trip   = reg_write && reg_addr == lsp_pkg::ADDR_TRIP_LEVEL;
  assign wr_extra  = reg_write && reg_addr == lsp_pkg::ADDR_EXTRA_TRIP;
  assign wr_target = reg_write && reg_addr == lsp_pkg::ADDR_TARGET_LEVEL;

  always_ff @(posedge clock) begin
    if (reset) begin
      switch_on_bit_ff         <= lsp_pkg::RST_SWITCH_CONTROL[lsp_pkg::BIT_SWITCH_ON];
      probe_mode_on_ff         <= lsp_pkg::RST_SWITCH_CONTROL[lsp_pkg::BIT_PROBE_MODE];
      trip_level_sel_ff        <= lsp_pkg::RST_TRIP_LEVEL_SEL;
      trip_fine_trim_ff        <= lsp_pkg::RST_FINE_TRIM;
      extra_trip_level_sel_ff  <= lsp_pkg::RST_EXTRA_TRIP_SEL;
      probe_current_sel_ff     <= lsp_pkg::RST_PROBE_CURRENT;
      probe_pulse_width_sel_ff <= lsp_pkg::RST_PULSE_WIDTH;
      repeat_period_sel_ff     <= lsp_pkg::RST_REPEAT_PERIOD;
      compare_target_ff        <= lsp_pkg::RST_TARGET_LEVEL;
      ramp_time_sel_ff         <= lsp_pkg::RST_RAMP_TIME_SEL;
    end else if (reg_write) begin
      unique case (reg_addr)
        lsp_pkg::ADDR_SWITCH_CONTROL: begin
          switch_on_bit_ff <= reg_wdata[lsp_pkg::BIT_SWITCH_ON];
          probe_mode_on_ff <= reg_wdata[lsp_pkg::BIT_PROBE_MODE];
        end
        lsp_pkg::ADDR_TRIP_LEVEL: begin
          trip_level_sel_ff <= reg_wdata[1:0];
          trip_fine_trim_ff <= reg_wdata[lsp_pkg::POS_FINE_TRIM +: 3];
        end
        lsp_pkg::ADDR_PROBE_CURRENT: probe_current_sel_ff <= reg_wdata[3:0];
        lsp_pkg::ADDR_PROBE_TIMING: begin
          probe_pulse_width_sel_ff <= reg_wdata[7:4];
          repeat_period_sel_ff     <= reg_wdata[3:0];
        end
        lsp_pkg::ADDR_TARGET_LEVEL: compare_target_ff <= reg_wdata;
        lsp_pkg::ADDR_EXTRA_TRIP: extra_trip_level_sel_ff <= reg_wdata[1:0];
        lsp_pkg::ADDR_RAMP_CONFIG: ramp_time_sel_ff <= reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  // Trip level source. The external pin is sampled one cycle after reset release,
  // so the synchroniser has settled; a later write to the trip level or extra trip register hands control to software.
  logic       strap_done_ff;
  lsp_pkg::lsp_trip_t trip_cfg_ff;

  always_ff @(posedge clock) begin
    if (reset) begin
      strap_done_ff <= 1'b0;
      trip_cfg_ff   <= '{use_external: 1'b0,
                         trip_level_sel: lsp_pkg::RST_TRIP_LEVEL_SEL,
                         extra_trip_level_sel: lsp_pkg::RST_EXTRA_TRIP_SEL,
                         trip_fine_trim: lsp_pkg::RST_FINE_TRIM};
    end else begin
      strap_done_ff <= 1'b1;
      if (!strap_done_ff) begin
        trip_cfg_ff.use_external <= !pin_ff.ext_pin_low;
      end else if (wr_trip || wr_extra) begin
        trip_cfg_ff.use_external <= 1'b0;
      end
      trip_cfg_ff.trip_level_sel       <= trip_level_sel_ff;
      trip_cfg_ff.extra_trip_level_sel <= extra_trip_level_sel_ff;
      trip_cfg_ff.trip_fine_trim       <= trip_fine_trim_ff;
    end
  end

  // Protection trips. Thermal has hysteresis between the hot and cool comparators.
  logic thermal_trip_ff;
  logic overcurrent_trip_ff;
  logic switch_on_ff;
  logic switch_full_ff;

  always_ff @(posedge clock) begin
    if (reset) begin
      thermal_trip_ff <= 1'b0;
    end else if (pin_ff.en_n || pin_ff.temp_cool) begin
      thermal_trip_ff <= 1'b0;
    end else if (pin_ff.temp_hot) begin
      thermal_trip_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      overcurrent_trip_ff <= 1'b0;
    end else if (pin_ff.en_n || !pin_ff.overcurrent) begin
      overcurrent_trip_ff <= 1'b0;
    end else if (switch_full_ff) begin
      overcurrent_trip_ff <= 1'b1;
    end
  end

  // Main switch decision. Under reverse supply the thermal trip no longer opens the
  // switch, because opening it would force the current through the body diode.
  logic nxt_switch_on;

  always_comb begin
    nxt_switch_on = !pin_ff.en_n
                    && pin_ff.above_lockout
                    && !pin_ff.above_trip
                    && !overcurrent_trip_ff
                    && !(thermal_trip_ff && !pin_ff.reverse_supply);
  end

  // Ramp timer: the switch counts as fully on once the selected ramp time elapses.
  logic [31:0] ramp_cnt_ff;

  always_ff @(posedge clock) begin
    if (reset) begin
      switch_on_ff   <= 1'b0;
      switch_full_ff <= 1'b0;
      ramp_cnt_ff    <= 32'h00000000;
    end else begin
      switch_on_ff <= nxt_switch_on;
      if (!nxt_switch_on) begin
        switch_full_ff <= 1'b0;
        ramp_cnt_ff    <= 32'h00000000;
      end else if (us_tick_ff && !switch_full_ff) begin
        if (ramp_cnt_ff + 32'h00000001 >= lsp_pkg::ramp_us(ramp_time_sel_ff)) begin
          switch_full_ff <= 1'b1;
        end
        ramp_cnt_ff <= ramp_cnt_ff + 32'h00000001;
      end
    end
  end

  // Impedance probe sequencer.
  lsp_pkg::lsp_det_t det_state_ff;
  logic [31:0]       det_cnt_ff;
  logic              probe_allowed;
  logic              pulse_start;
  logic              pulse_expire;
  logic [7:0]        measured_ff;
  logic              probe_done_ff;
  logic              below_target_ff;

  assign probe_allowed = !pin_ff.en_n && !pin_ff.above_lockout
                         && probe_mode_on_ff && switch_on_bit_ff;
  assign pulse_expire  = det_state_ff == lsp_pkg::DET_PULSE && probe_allowed
                         && probe_pulse_width_sel_ff != lsp_pkg::PULSE_ALWAYS_ON
                         && us_tick_ff
                         && det_cnt_ff + 32'h00000001
                            >= lsp_pkg::pulse_us(probe_pulse_width_sel_ff);
  assign pulse_start   = probe_allowed
                         && ((det_state_ff == lsp_pkg::DET_ARMED && wr_target)
                          || (det_state_ff == lsp_pkg::DET_WAIT && us_tick_ff
                              && det_cnt_ff + 32'h00000001
                                 >= lsp_pkg::period_us(repeat_period_sel_ff)));

  always_ff @(posedge clock) begin
    if (reset) begin
      det_state_ff <= lsp_pkg::DET_IDLE;
      det_cnt_ff   <= 32'h00000000;
    end else if (!probe_allowed) begin
      det_state_ff <= lsp_pkg::DET_IDLE;
      det_cnt_ff   <= 32'h00000000;
    end else begin
      unique case (det_state_ff)
        lsp_pkg::DET_IDLE: det_state_ff <= lsp_pkg::DET_ARMED;
        lsp_pkg::DET_ARMED, lsp_pkg::DET_WAIT: begin
          if (pulse_start) begin
            det_state_ff <= lsp_pkg::DET_PULSE;
            det_cnt_ff   <= 32'h00000000;
          end else if (us_tick_ff) begin
            det_cnt_ff <= det_cnt_ff + 32'h00000001;
          end
        end
        lsp_pkg::DET_PULSE: begin
          if (pulse_expire) begin
            det_cnt_ff <= 32'h00000000;
            if (repeat_period_sel_ff == lsp_pkg::PERIOD_SINGLE) begin
              det_state_ff <= lsp_pkg::DET_ARMED;
            end else begin
              det_state_ff <= lsp_pkg::DET_WAIT;
            end
          end else if (us_tick_ff) begin
            det_cnt_ff <= det_cnt_ff + 32'h00000001;
          end
        end
      endcase
    end
  end

  // Result capture happens only when the pulse timer expires.
  always_ff @(posedge clock) begin
    if (reset) begin
      measured_ff     <= 8'h00;
      probe_done_ff   <= 1'b0;
      below_target_ff <= 1'b0;
    end else if (pulse_expire) begin
      measured_ff     <= adc_level;
      probe_done_ff   <= 1'b1;
      below_target_ff <= adc_level < compare_target_ff;
    end else if (pulse_start) begin
      probe_done_ff   <= 1'b0;
      below_target_ff <= 1'b0;
    end
  end

  // Fault flags. A setting condition in the cycle of a clearing read wins.
  logic [2:0] flags_ff;
  logic [2:0] flag_set;
  logic       rd_flags;
  logic       rd_status;

  assign rd_flags  = reg_read && reg_addr == lsp_pkg::ADDR_FAULT_FLAGS;
  assign rd_status = reg_read && reg_addr == lsp_pkg::ADDR_LIVE_STATUS;

  always_comb begin
    flag_set                          = 3'h0;
    flag_set[lsp_pkg::BIT_INPUT_TRIP] = !pin_ff.en_n && pin_ff.above_trip;
    flag_set[lsp_pkg::BIT_THERMAL]    = thermal_trip_ff;
    flag_set[lsp_pkg::BIT_OVERCURRENT] = overcurrent_trip_ff;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      flags_ff <= 3'h0;
    end else if (rd_flags || !pin_ff.above_lockout) begin
      flags_ff <= flag_set;
    end else begin
      flags_ff <= flags_ff | flag_set;
    end
  end

  // Live status; the reverse-supply bit is reported but raises no event.
  logic [7:0] status;

  always_comb begin
    status                           = 8'h00;
    status[lsp_pkg::BIT_REVERSE_STS] = pin_ff.reverse_supply;
    status[lsp_pkg::BIT_PROBE_DONE]  = probe_done_ff;
    status[lsp_pkg::BIT_BELOW_TGT]   = below_target_ff;
    status[lsp_pkg::BIT_INPUT_OK]    = pin_ff.above_lockout;
  end

  // Interrupt events: one per rising edge, held until read, pulse start or disable.
  logic [2:0] flag_prev_ff;
  logic [2:0] status_prev_ff;
  logic [2:0] flag_evt_ff;
  logic [2:0] status_evt_ff;
  logic [2:0] status_src;
  logic       irq_ff;

  assign status_src = status[lsp_pkg::BIT_INPUT_OK:lsp_pkg::BIT_PROBE_DONE];

  always_ff @(posedge clock) begin
    if (reset) begin
      // Starting from the live status keeps a present input from posing as an event.
      flag_prev_ff   <= 3'h0;
      status_prev_ff <= status_src;
      flag_evt_ff    <= 3'h0;
      status_evt_ff  <= 3'h0;
    end else begin
      flag_prev_ff   <= flags_ff;
      status_prev_ff <= status_src;
      if (rd_flags || pulse_start || pin_ff.en_n) begin
        flag_evt_ff <= flags_ff & ~flag_prev_ff;
      end else begin
        flag_evt_ff <= flag_evt_ff | (flags_ff & ~flag_prev_ff);
      end
      if (rd_status || pulse_start || pin_ff.en_n) begin
        status_evt_ff <= status_src & ~status_prev_ff;
      end else begin
        status_evt_ff <= status_evt_ff | (status_src & ~status_prev_ff);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |{flag_evt_ff, status_evt_ff};
    end
  end

  // Register read port; unmapped offsets read as zero.
  logic [7:0] reg_rdata_ff;
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 8'h00;
    unique case (reg_addr)
      lsp_pkg::ADDR_SWITCH_CONTROL: begin
        nxt_rdata[lsp_pkg::BIT_SWITCH_ON]  = switch_on_bit_ff;
        nxt_rdata[lsp_pkg::BIT_PROBE_MODE] = probe_mode_on_ff;
      end
      lsp_pkg::ADDR_LIVE_STATUS:    nxt_rdata = status;
      lsp_pkg::ADDR_FAULT_FLAGS:    nxt_rdata = {5'h00, flags_ff};
      lsp_pkg::ADDR_TRIP_LEVEL:     nxt_rdata = {1'b0, trip_fine_trim_ff, 2'h0, trip_level_sel_ff};
      lsp_pkg::ADDR_PROBE_CURRENT:  nxt_rdata = {4'h0, probe_current_sel_ff};
      lsp_pkg::ADDR_PROBE_TIMING:   nxt_rdata = {probe_pulse_width_sel_ff, repeat_period_sel_ff};
      lsp_pkg::ADDR_MEASURED_LEVEL: nxt_rdata = measured_ff;
      lsp_pkg::ADDR_TARGET_LEVEL:   nxt_rdata = compare_target_ff;
      lsp_pkg::ADDR_EXTRA_TRIP:     nxt_rdata = {6'h00, extra_trip_level_sel_ff};
      lsp_pkg::ADDR_RAMP_CONFIG:    nxt_rdata = {5'h00, ramp_time_sel_ff};
      default: ;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_read) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // Output stage.
  logic       probe_active_ff;
  logic [3:0] probe_current_out_ff;
  logic       low_power_ff;
  logic [2:0] ramp_out_ff;

  always_ff @(posedge clock) begin
    if (reset) begin
      probe_active_ff      <= 1'b0;
      probe_current_out_ff <= 4'h0;
      low_power_ff         <= 1'b0;
      ramp_out_ff          <= lsp_pkg::RST_RAMP_TIME_SEL;
    end else begin
      probe_active_ff      <= det_state_ff == lsp_pkg::DET_PULSE && probe_allowed;
      probe_current_out_ff <= probe_current_sel_ff;
      low_power_ff         <= pin_ff.en_n;
      ramp_out_ff          <= ramp_time_sel_ff;
    end
  end

  assign reg_rdata         = reg_rdata_ff;
  assign switch_on         = switch_on_ff;
  assign switch_full       = switch_full_ff;
  assign ramp_time_sel     = ramp_out_ff;
  assign trip_cfg          = trip_cfg_ff;
  assign probe_current_sel = probe_current_out_ff;
  assign probe_active      = probe_active_ff;
  assign low_power         = low_power_ff;
  assign irq               = irq_ff;

endmodule // lsp_core

// ---- sim/lsp_checker.sv ----
// Checker of switch gating, probe gating and interrupt timing of the load switch core.
`timescale 1ns/1ps
module lsp_checker (
  input wire logic               clock,
  input wire logic               reset,
  input wire lsp_pkg::lsp_pins_t pin_in,
  input wire logic               switch_on,
  input wire logic               probe_active,
  input wire logic               low_power,
  input wire logic               irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // Five cycles cover the two synchroniser flops and the output flop.
  sequence s_run;
    (!pin_in.en_n && pin_in.above_lockout && !pin_in.above_trip && !pin_in.temp_hot
      && pin_in.temp_cool && !pin_in.overcurrent) [*5];
  endsequence
  sequence s_otg_hot;
    (!pin_in.en_n && pin_in.above_lockout && !pin_in.above_trip && pin_in.reverse_supply
      && !pin_in.overcurrent) [*5];
  endsequence
  a_enable_off: assert property (pin_in.en_n [*5] |-> !switch_on) else $error("on");
  a_low_power: assert property (pin_in.en_n [*5] |-> low_power) else $error("lp");
  a_lockout_off: assert property (!pin_in.above_lockout [*5] |-> !switch_on) else $error("uv");
  a_trip_off: assert property (pin_in.above_trip [*5] |-> !switch_on) else $error("ov");
  a_auto_on: assert property (s_run |-> switch_on) else $error("not on");
  a_otg_keep: assert property (s_otg_hot |-> switch_on) else $error("otg off");
  a_trip_irq: assert property ($rose(pin_in.above_trip) && !pin_in.en_n |-> ##[2:6] irq)
    else $error("no irq");
  a_probe_gate: assert property (pin_in.above_lockout [*5] |-> !probe_active)
    else $error("probe");
endmodule // lsp_checker

bind lsp_core lsp_checker lsp_checker_i (.clock, .reset, .pin_in, .switch_on, .probe_active,
  .low_power, .irq);

// ---- sim/lsp_host.sv ----
// Host model issuing register writes and reads to the load switch core.
`timescale 1ns/1ps
module lsp_host (
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_write,
  output logic            reg_read
);
  initial {reg_addr, reg_wdata, reg_write, reg_read} = 18'h00000;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule // lsp_host

// ---- sim/lsp_core_tb.sv ----
// Self-checking testbench of the load switch core.
`timescale 1ns/1ps
module lsp_core_tb;
  logic               clock;
  logic               reset;
  lsp_pkg::lsp_pins_t pin_in;
  lsp_pkg::lsp_trip_t trip_cfg;
  logic [7:0]         adc_level, reg_addr, reg_wdata, reg_rdata;
  logic               reg_write, reg_read, switch_on, switch_full, probe_active, low_power, irq;
  logic [2:0]         ramp_time_sel;
  logic [3:0]         probe_current_sel;
  int                 fails = 0;
  int                 compares = 0;
  lsp_core #(.US_CYCLES(4)) lsp_core_i (.clock, .reset, .pin_in, .adc_level, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .switch_on, .switch_full, .ramp_time_sel,
    .trip_cfg, .probe_current_sel, .probe_active, .low_power, .irq);
  lsp_host lsp_host_i (.clock, .reg_rdata, .reg_addr, .reg_wdata, .reg_write, .reg_read);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    lsp_host_i.rd(a, v);
    chk(v, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Pin patterns are {en_n, lockout, trip, hot, cool, oc, reverse, ext_low}.
  task automatic setp(input logic [7:0] p);
    @(posedge clock);
    pin_in <= lsp_pkg::lsp_pins_t'(p);
    cyc(5);
  endtask
  task automatic t_regs;
    chk(trip_cfg, 8'h03);
    rc(8'h01, 8'h00);
    rc(8'h05, 8'h30);
    rc(8'h0F, 8'h04);
    rc(8'h04, 8'h00);
    lsp_host_i.wr(8'h0F, 8'h07);
    lsp_host_i.wr(8'h05, 8'h23);
    cyc(1);
    chk({5'h00, ramp_time_sel}, 8'h07);
    chk(trip_cfg, 8'h62);
    lsp_host_i.wr(8'h0E, 8'h02);
    cyc(1);
    chk(trip_cfg, 8'h72);
    $display("regs done");
  endtask
  task automatic t_switch;
    setp(8'h49);
    chk({7'h00, switch_on}, 8'h01);
    setp(8'hC9);
    chk({6'h00, switch_on, low_power}, 8'h01);
    setp(8'h49);
    setp(8'h69);
    chk({6'h00, switch_on, irq}, 8'h01);
    rc(8'h03, 8'h01);
    setp(8'h49);
    chk({7'h00, switch_on}, 8'h01);
    rc(8'h03, 8'h01);
    rc(8'h03, 8'h00);
    chk({7'h00, irq}, 8'h00);
    $display("switch done");
  endtask
  task automatic t_thermal;
    setp(8'h51);
    chk({7'h00, switch_on}, 8'h00);
    rc(8'h03, 8'h02);
    setp(8'h49);
    chk({7'h00, switch_on}, 8'h01);
    rc(8'h03, 8'h02);
    setp(8'h53);
    cyc(1);
    chk({6'h00, switch_on, irq}, 8'h03);
    setp(8'h49);
    rc(8'h03, 8'h02);
    $display("thermal done");
  endtask
  task automatic t_overcurrent;
    chk({7'h00, switch_full}, 8'h00);
    lsp_host_i.wr(8'h0F, 8'h00);
    cyc(1700);
    chk({7'h00, switch_full}, 8'h01);
    setp(8'h4D);
    chk({7'h00, switch_on}, 8'h00);
    rc(8'h03, 8'h04);
    setp(8'h49);
    chk({7'h00, switch_on}, 8'h01);
    $display("overcurrent done");
  endtask
  task automatic t_strap;
    @(posedge clock);
    reset  <= 1'b1;
    pin_in <= lsp_pkg::lsp_pins_t'(8'hC8);
    cyc(4);
    @(posedge clock);
    reset <= 1'b0;
    cyc(2);
    chk(trip_cfg, 8'h83);
    chk({7'h00, irq}, 8'h00);
    lsp_host_i.wr(8'h05, 8'h30);
    cyc(1);
    chk(trip_cfg, 8'h03);
    $display("strap done");
  endtask
  task automatic t_probe;
    setp(8'h09);
    lsp_host_i.wr(8'h01, 8'hC0);
    lsp_host_i.wr(8'h06, 8'h0D);
    lsp_host_i.wr(8'h07, 8'h00);
    lsp_host_i.wr(8'h09, 8'h80);
    cyc(3);
    chk({3'h0, probe_active, probe_current_sel}, 8'h1D);
    cyc(820);
    chk({7'h00, probe_active}, 8'h00);
    chk({7'h00, irq}, 8'h01);
    rc(8'h08, 8'h40);
    rc(8'h02, 8'h06);
    lsp_host_i.wr(8'h09, 8'h80);
    setp(8'h49);
    chk({7'h00, probe_active}, 8'h00);
    $display("probe done");
  endtask
  task automatic stop_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    pin_in = lsp_pkg::lsp_pins_t'(8'hC9);
    adc_level = 8'h40;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    cyc(3);
    t_regs;
    t_switch;
    t_thermal;
    t_overcurrent;
    t_probe;
    t_strap;
    stop_test;
  end
  // The tests take about 2700 cycles; this cuts a hang well after that.
  initial begin
    #40000;
    fails++;
    stop_test;
  end
endmodule // lsp_core_tb
